// [pkg/oak_pkg.sv]
// constants, register map and state type of the output acknowledge timing block
package oak_pkg;
    // core clock
    localparam int CLK_NS = 8;
    // fast acknowledge hold and the chain steps it spans, gen set to gen clear
    localparam int ACK_HOLD_NS = 2750;
    localparam int ACK_STEPS = 39;
    localparam int PHASE_CYC = ACK_HOLD_NS / (ACK_STEPS * CLK_NS);
    // slow interface delays, least times rounded up
    localparam int SLOW_HOLD_NS = 14870;
    localparam int SLOW_GEN_NS = 4300;
    localparam int SLOW_GEN_CYC = (SLOW_GEN_NS + CLK_NS - 1) / CLK_NS;
    localparam int SLOW_STAGE_NS = 10700;
    localparam int SLOW_STAGE_CYC = (SLOW_STAGE_NS + CLK_NS - 1) / CLK_NS;
    localparam int WAIT_W = 11;
    // chain steps, time t phase p is (t-1)*4 + (p-1)
    localparam logic [3:0] STEP_T1_2 = 4'h1;
    localparam logic [3:0] STEP_T1_3 = 4'h2;
    localparam logic [3:0] STEP_T1_4 = 4'h3;
    localparam logic [3:0] STEP_T2_2 = 4'h5;
    localparam logic [3:0] STEP_T3_2 = 4'h9;
    localparam logic [3:0] STEP_T3_4 = 4'hB;
    localparam logic [3:0] STEP_T4_1 = 4'hC;
    localparam logic [3:0] STEP_T4_4 = 4'hF;
    // register map, byte addresses
    localparam int ADDR_W = 4;
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_ACTIVE = 4'h4;
    localparam logic [3:0] REG_STATUS = 4'h8;
    localparam logic [3:0] REG_CHAIN = 4'hC;
    // control fields
    localparam int CTRL_SLOW_BIT = 0;
    localparam int CTRL_INTER_BIT = 1;
    localparam logic [1:0] CTRL_RESET = 2'h0;
    // status fields
    localparam int ST_KIND_BIT = 0;
    localparam int ST_DELAY_BIT = 1;
    localparam int ST_GEN_BIT = 2;
    localparam int ST_STAGE_BIT = 3;
    localparam int ST_RESUME_BIT = 4;
    localparam int ST_TERM_BIT = 5;
    localparam int ST_BUSY_BIT = 6;
    localparam int ST_REQ_LSB = 8;
    localparam int MAX_CHAN = 8;
    // words needed before the acknowledge
    localparam logic [1:0] WORDS_SINGLE = 2'h1;
    localparam logic [1:0] WORDS_DUAL = 2'h2;
    // sequence states
    typedef enum logic [2:0] {
        SEQ_IDLE,
        SEQ_WORDS,
        SEQ_ARMED,
        SEQ_REQ,
        SEQ_DELAY,
        SEQ_ACK
    } oak_seq_t;
endpackage

// [verilog/oak_ack_timing.sv]
// output word acknowledge sequencer driven by a four-time, four-phase chain
//
// Contract
// - at T1.2 clear every channel acknowledge request flag before a new sequence
// - at T1.3 set transfer kind flag for external function, clear it for data
// - at T1.3 set only the serviced channel's request flag
// - fast: delay flag set at T1.4, generator sets at next T3.4, ack out
// - resume sets at T4.1 with request and delay set, normal mode selected
// - terminate on data transfer clears only requested channel's active flag at resume
// - after resume, terminate flag clears at T4.4
// - after resume, delay flag clears at T3.2
// - after delay clears, generator clears at next T1.3, dropping ack
// - ack only after the word, or both words in dual operation, went out
// - ack held 2.75 us fast, about 14.87 us slow; here held 312 clocks (2.496 us) fast, 1720 clocks (13.76 us) slow
//
// Chosen here: the register addresses and strobed register access.
module oak_ack_timing #(
    parameter int CHAN = 4,
    parameter int CW = $clog2(CHAN)
) (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    // register port
    input wire logic [oak_pkg::ADDR_W-1:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [31:0] reg_rdata_o,
    // transfer side
    input wire logic start_i,
    input wire logic [CW-1:0] start_chan_i,
    input wire logic start_ef_i,
    input wire logic start_term_i,
    input wire logic start_dual_i,
    input wire logic word_done_i,
    output logic busy_o,
    // peripheral side
    output logic od_ack_o,
    output logic ef_ack_o,
    output logic resume_o,
    // timing chain
    output logic [3:0] chain_step_o
);

    // the status field holds at most eight request flags
    if (CHAN < 2 || CHAN > oak_pkg::MAX_CHAN || CW != $clog2(CHAN))
    begin : g_bad_chan
        $error("oak_ack_timing: CHAN must be 2..8 and CW its log2");
    end

    ////////////////////////////////////////////////////////////////////////////////
    // step decode shared by every action
    function automatic logic at_step(input logic tick, input logic [3:0] step,
                                     input logic [3:0] want);
        at_step = tick && (step == want);
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // timing chain
    localparam int PW = $clog2(oak_pkg::PHASE_CYC + 1);
    localparam logic [PW-1:0] PHASE_LAST = PW'(oak_pkg::PHASE_CYC - 1);

    logic [PW-1:0] phase_cnt;
    logic [3:0] step;
    logic tick;

    assign tick = (phase_cnt == PHASE_LAST);

    // each phase lasts PHASE_CYC clocks; the chain never stops
    always_ff @(posedge core_clk_i)
    begin
        if (!rst_n_i)
        begin
            phase_cnt <= '0;
            step <= 4'h0;
        end
        else
        begin
            phase_cnt <= tick ? '0 : phase_cnt + PW'(1);
            step <= tick ? step + 4'h1 : step;
        end
    end

    wire s_t1_2 = at_step(tick, step, oak_pkg::STEP_T1_2);
    wire s_t1_3 = at_step(tick, step, oak_pkg::STEP_T1_3);
    wire s_t1_4 = at_step(tick, step, oak_pkg::STEP_T1_4);
    wire s_t2_2 = at_step(tick, step, oak_pkg::STEP_T2_2);
    wire s_t3_2 = at_step(tick, step, oak_pkg::STEP_T3_2);
    wire s_t3_4 = at_step(tick, step, oak_pkg::STEP_T3_4);
    wire s_t4_1 = at_step(tick, step, oak_pkg::STEP_T4_1);
    wire s_t4_4 = at_step(tick, step, oak_pkg::STEP_T4_4);

    ////////////////////////////////////////////////////////////////////////////////
    // flags and sequence state
    oak_pkg::oak_seq_t state;
    oak_pkg::oak_seq_t next_state;
    logic [CHAN-1:0] req_flag;
    logic [CHAN-1:0] active_flag;
    logic [CW-1:0] chan;
    logic [1:0] words_need;
    logic [1:0] words_seen;
    logic [1:0] ctrl;
    logic start_kind; // kind held from the start until T1.3 loads the flag
    logic kind_flag;
    logic delay_flag;
    logic gen_flag;
    logic stage_flag;
    logic resume_flag;
    logic term_flag;
    logic [oak_pkg::WAIT_W-1:0] wait_cnt;

    wire slow_if = ctrl[oak_pkg::CTRL_SLOW_BIT];
    wire inter_mode = ctrl[oak_pkg::CTRL_INTER_BIT];
    wire in_ack = (state == oak_pkg::SEQ_ACK);
    wire take_start = start_i && (state == oak_pkg::SEQ_IDLE);

    // slow interface replaces the chain-only timing by two delay lines
    wire slow_gen_ok = !slow_if || (wait_cnt >= oak_pkg::WAIT_W'(oak_pkg::SLOW_GEN_CYC));
    wire slow_stage_ok = !slow_if ||
                         (wait_cnt >= oak_pkg::WAIT_W'(oak_pkg::SLOW_STAGE_CYC));

    // event conditions
    wire words_ok = (words_seen >= words_need);
    wire set_delay = (state == oak_pkg::SEQ_DELAY) && s_t1_4;
    wire set_gen = in_ack && s_t3_4 && delay_flag && !gen_flag && !resume_flag &&
                   slow_gen_ok;
    wire set_stage = in_ack && s_t1_2 && gen_flag && !stage_flag && !resume_flag &&
                     slow_stage_ok;
    // test-resume path opens only in normal mode, after the completion stage
    wire set_resume = in_ack && s_t4_1 && req_flag[chan] && delay_flag && stage_flag &&
                      !resume_flag && !inter_mode;
    wire clr_term = in_ack && s_t4_4 && resume_flag;
    wire clr_delay = in_ack && s_t3_2 && resume_flag;
    wire clr_gen = in_ack && s_t1_3 && gen_flag && !delay_flag && resume_flag;
    wire clr_stage = in_ack && s_t2_2 && stage_flag && !gen_flag && resume_flag;
    wire [CHAN-1:0] act_clr = (set_resume && term_flag && !kind_flag) ?
                              req_flag : '0;

    // register port decode
    wire wr_ctrl = reg_wr_i && (reg_addr_i == oak_pkg::REG_CTRL);
    wire wr_active = reg_wr_i && (reg_addr_i == oak_pkg::REG_ACTIVE);

    // sequence progress
    always_comb
    begin
        next_state = state;
        case (state)
            oak_pkg::SEQ_IDLE:
                if (take_start)
                    next_state = oak_pkg::SEQ_WORDS;
            oak_pkg::SEQ_WORDS:
                if (words_ok)
                    next_state = oak_pkg::SEQ_ARMED;
            oak_pkg::SEQ_ARMED:
                if (s_t1_2)
                    next_state = oak_pkg::SEQ_REQ;
            oak_pkg::SEQ_REQ:
                if (s_t1_3)
                    next_state = oak_pkg::SEQ_DELAY;
            oak_pkg::SEQ_DELAY:
                if (s_t1_4)
                    next_state = oak_pkg::SEQ_ACK;
            oak_pkg::SEQ_ACK:
                if (clr_stage)
                    next_state = oak_pkg::SEQ_IDLE;
            default:
                next_state = oak_pkg::SEQ_IDLE;
        endcase
    end

    // start capture and word counting; a start while busy is ignored
    always_ff @(posedge core_clk_i)
    begin
        if (!rst_n_i)
        begin
            state <= oak_pkg::SEQ_IDLE;
            chan <= '0;
            words_need <= oak_pkg::WORDS_SINGLE;
            words_seen <= 2'h0;
            start_kind <= 1'b0;
        end
        else
        begin
            state <= next_state;
            if (take_start)
            begin
                chan <= start_chan_i;
                words_need <= start_dual_i ? oak_pkg::WORDS_DUAL : oak_pkg::WORDS_SINGLE;
                start_kind <= start_ef_i;
                words_seen <= 2'h0;
            end
            else if (state == oak_pkg::SEQ_WORDS && word_done_i && !words_ok)
            begin
                words_seen <= words_seen + 2'h1;
            end
        end
    end

    // request and kind flags
    always_ff @(posedge core_clk_i)
    begin
        if (!rst_n_i)
        begin
            req_flag <= '0;
            kind_flag <= 1'b0;
        end
        else if (state == oak_pkg::SEQ_ARMED && s_t1_2)
        begin
            req_flag <= '0;
        end
        else if (state == oak_pkg::SEQ_REQ && s_t1_3)
        begin
            req_flag <= CHAN'(1) << chan;
            kind_flag <= start_kind;
        end
    end

    // acknowledge timing flags
    always_ff @(posedge core_clk_i)
    begin
        if (!rst_n_i)
        begin
            delay_flag <= 1'b0;
            gen_flag <= 1'b0;
            stage_flag <= 1'b0;
        end
        else
        begin
            delay_flag <= set_delay || (delay_flag && !clr_delay);
            gen_flag <= set_gen || (gen_flag && !clr_gen);
            stage_flag <= set_stage || (stage_flag && !clr_stage);
        end
    end

    // resume stays up until the next sequence reaches its T1.2
    always_ff @(posedge core_clk_i)
    begin
        if (!rst_n_i)
            resume_flag <= 1'b0;
        else if (set_resume)
            resume_flag <= 1'b1;
        else if (state == oak_pkg::SEQ_ARMED && s_t1_2)
            resume_flag <= 1'b0;
    end

    // terminate flag: start sets it, set wins over the T4.4 clear
    always_ff @(posedge core_clk_i)
    begin
        if (!rst_n_i)
            term_flag <= 1'b0;
        else if (take_start && start_term_i)
            term_flag <= 1'b1;
        else if (clr_term)
            term_flag <= 1'b0;
    end

    // slow delay lines share one counter, restarted at delay set and gen set
    always_ff @(posedge core_clk_i)
    begin
        if (!rst_n_i)
            wait_cnt <= '0;
        else if (set_delay || set_gen)
            wait_cnt <= '0;
        else if (wait_cnt != '1)
            wait_cnt <= wait_cnt + oak_pkg::WAIT_W'(1);
    end

    ////////////////////////////////////////////////////////////////////////////////
    // registers: control, channel active, status, chain
    always_ff @(posedge core_clk_i)
    begin
        if (!rst_n_i)
        begin
            ctrl <= oak_pkg::CTRL_RESET;
            active_flag <= '0;
        end
        else
        begin
            if (wr_ctrl)
            begin
                ctrl <= reg_wdata_i[1:0];
            end
            // the terminate clear wins so a finished buffer is never revived
            active_flag <= (wr_active ? reg_wdata_i[CHAN-1:0] : active_flag) &
                           ~act_clr;
        end
    end

    // status word
    logic [31:0] status_word;
    always_comb
    begin
        status_word = 32'h0000_0000;
        status_word[oak_pkg::ST_KIND_BIT] = kind_flag;
        status_word[oak_pkg::ST_DELAY_BIT] = delay_flag;
        status_word[oak_pkg::ST_GEN_BIT] = gen_flag;
        status_word[oak_pkg::ST_STAGE_BIT] = stage_flag;
        status_word[oak_pkg::ST_RESUME_BIT] = resume_flag;
        status_word[oak_pkg::ST_TERM_BIT] = term_flag;
        status_word[oak_pkg::ST_BUSY_BIT] = (state != oak_pkg::SEQ_IDLE);
        status_word[oak_pkg::ST_REQ_LSB +: CHAN] = req_flag;
    end

    // read mux; unmapped addresses read zero
    wire [31:0] rd_mux =
        (reg_addr_i == oak_pkg::REG_CTRL) ? {30'h0, ctrl} :
        (reg_addr_i == oak_pkg::REG_ACTIVE) ? {{(32 - CHAN){1'b0}}, active_flag} :
        (reg_addr_i == oak_pkg::REG_STATUS) ? status_word :
        (reg_addr_i == oak_pkg::REG_CHAIN) ? {28'h0, step} : 32'h0000_0000;

    // read data stands only in the cycle after the strobe
    always_ff @(posedge core_clk_i)
    begin
        if (!rst_n_i)
            reg_rdata_o <= 32'h0000_0000;
        else
            reg_rdata_o <= reg_rd_i ? rd_mux : 32'h0000_0000;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // outputs; the kind flag steers which acknowledge line carries the pulse
    assign od_ack_o = gen_flag && !kind_flag;
    assign ef_ack_o = gen_flag && kind_flag;
    assign resume_o = resume_flag;
    assign busy_o = (state != oak_pkg::SEQ_IDLE);
    assign chain_step_o = step;

endmodule

// [test/oak_ack_timing_checker.sv]
// concurrent checks on the ports of the output acknowledge timing block
module oak_ack_timing_checker (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    // observed outputs
    input wire logic busy_o,
    input wire logic od_ack_o,
    input wire logic ef_ack_o,
    input wire logic resume_o,
    input wire logic [3:0] chain_step_o
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int ACK_MIN = oak_pkg::ACK_STEPS * oak_pkg::PHASE_CYC;
    logic ack;
    logic [15:0] ack_cnt;
    default clocking @(posedge core_clk_i);
    endclocking
    default disable iff (!rst_n_i);
    assign ack = od_ack_o | ef_ack_o;
    // length of the current ack, saturating so a stuck ack never wraps
    always_ff @(posedge core_clk_i)
    begin
        if (!rst_n_i || !ack)
            ack_cnt <= 16'h0000;
        else if (ack_cnt != 16'hFFFF)
            ack_cnt <= ack_cnt + 16'h0001;
    end
    ////////////////////////////////////////////////////////////////////////////
    sequence ack_up_s;
        $rose(ack);
    endsequence
    sequence ack_down_s;
        $fell(ack);
    endsequence
    // every step lasts one full phase and the chain only moves forward
    step_order_a: assert property ($changed(chain_step_o) |->
        chain_step_o == $past(chain_step_o) + 4'h1) else $error("chain step skipped");
    step_hold_a: assert property ($changed(chain_step_o) |=>
        $stable(chain_step_o) [*7]) else $error("chain step too short");
    ack_rise_a: assert property (ack_up_s |->
        chain_step_o == oak_pkg::STEP_T4_1) else $error("ack rose off its step");
    ack_fall_a: assert property (ack_down_s |->
        chain_step_o == oak_pkg::STEP_T1_4) else $error("ack fell off its step");
    ack_width_a: assert property (ack_down_s |->
        ack_cnt >= ACK_MIN) else $error("ack too short");
    ack_kind_a: assert property (!(od_ack_o && ef_ack_o))
        else $error("both ack kinds high");
    ack_busy_a: assert property (ack_up_s |-> busy_o)
        else $error("ack without a sequence");
    resume_set_a: assert property ($rose(resume_o) |->
        ack && chain_step_o == 4'hD) else $error("resume set off its step");
    resume_clear_a: assert property ($fell(resume_o) |->
        chain_step_o == 4'h2) else $error("resume cleared off its step");
    busy_end_a: assert property ($fell(busy_o) |->
        chain_step_o == 4'h6 && !ack) else $error("sequence ended off its step");
endmodule
bind oak_ack_timing oak_ack_timing_checker u_chk (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .busy_o(busy_o),
    .od_ack_o(od_ack_o),
    .ef_ack_o(ef_ack_o),
    .resume_o(resume_o),
    .chain_step_o(chain_step_o)
);

// [test/oak_periph.sv]
// peripheral model: raises a data request and drops it once acknowledged
module oak_periph (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // handshake
    input wire logic ack_i,
    input wire logic slow_i,
    output logic odr_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [4:0] wait_cnt;
    // slow mode lingers 20 clocks, so the ack must outlast a sluggish receiver
    always @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            odr_o <= 1'b1;
            wait_cnt <= 5'h00;
        end
        else if (odr_o && ack_i)
        begin
            wait_cnt <= wait_cnt + 5'h01;
            if (!slow_i || wait_cnt == 5'h13)
                odr_o <= 1'b0;
        end
        else if (!ack_i)
        begin
            odr_o <= 1'b1;
            wait_cnt <= 5'h00;
        end
    end
endmodule

// [test/tb_top.sv]
// self-checking bench for the output acknowledge timing block
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [3:0] reg_addr_i = 4'h0;
    logic [31:0] reg_wdata_i = 32'h0;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic start_i = 1'b0;
    logic [1:0] start_chan_i = 2'h0;
    logic start_ef_i = 1'b0;
    logic start_term_i = 1'b0;
    logic start_dual_i = 1'b0;
    logic word_done_i = 1'b0;
    logic slow = 1'b0;
    logic busy_o, od_ack_o, ef_ack_o, resume_o, output_data_request;
    logic [3:0] chain_step_o;
    logic [31:0] reg_rdata_o, rd, rv;
    logic [31:0] ack_len = 32'h0;
    int errors = 0;
    int n_compared = 0;
    int seed = 32'h810C2F9A;
    oak_ack_timing #(.CHAN(4)) uut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
        .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .start_i(start_i),
        .start_chan_i(start_chan_i), .start_ef_i(start_ef_i), .start_term_i(start_term_i),
        .start_dual_i(start_dual_i), .word_done_i(word_done_i), .busy_o(busy_o),
        .od_ack_o(od_ack_o), .ef_ack_o(ef_ack_o), .resume_o(resume_o),
        .chain_step_o(chain_step_o));
    oak_periph u_periph (.clk_i(core_clk_i), .rst_n_i(rst_n_i),
        .ack_i(od_ack_o | ef_ack_o), .slow_i(slow), .odr_o(output_data_request));
    // 125 MHz core clock
    initial
    begin
        forever #4 core_clk_i = ~core_clk_i;
    end
    // ack length, cleared on the edge that takes a start so it has one driver
    always @(posedge core_clk_i)
        if (start_i && !busy_o)
            ack_len <= 32'h0;
        else if (od_ack_o | ef_ack_o)
            ack_len <= ack_len + 32'h1;
    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] exp_act(input int c, input logic ef, input logic t);
        return (t && !ef) ? (32'hF & ~(32'h1 << c)) : 32'hF;
    endfunction
    function automatic logic [31:0] exp_st(input int c, input logic ef, input logic [31:0] f);
        return (32'h1 << (8 + c)) | f | {31'h0, ef};
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge core_clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge core_clk_i);
        reg_wr_i <= 1'b0;
    endtask
    // data stand only in the cycle after the strobe, so sample just past that edge
    task automatic rdr(input logic [3:0] a, output logic [31:0] d);
        @(posedge core_clk_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge core_clk_i);
        reg_rd_i <= 1'b0;
        #1 d = reg_rdata_o;
    endtask
    task automatic word();
        @(posedge core_clk_i);
        word_done_i <= 1'b1;
        @(posedge core_clk_i);
        word_done_i <= 1'b0;
    endtask
    // one whole acknowledge sequence; a second start while busy must be ignored
    task automatic run_seq(input int c, input logic ef, input logic t, input logic du,
        input logic [1:0] md);
        wr(oak_pkg::REG_ACTIVE, 32'hF);
        wr(oak_pkg::REG_CTRL, {30'h0, md});
        for (int i = 0; i < 400 && output_data_request !== 1'b1; i++) @(posedge core_clk_i);
        @(posedge core_clk_i);
        start_i <= 1'b1;
        start_chan_i <= 2'(c);
        start_ef_i <= ef;
        start_term_i <= t;
        start_dual_i <= du;
        @(posedge core_clk_i);
        start_chan_i <= 2'(c + 1);
        start_ef_i <= !ef;
        @(posedge core_clk_i);
        start_i <= 1'b0;
        if (du)
        begin
            word();
            repeat (300) @(posedge core_clk_i);
            chk(32'(od_ack_o | ef_ack_o), 32'h0);
        end
        word();
        for (int i = 0; i < 4000 && !(od_ack_o | ef_ack_o); i++) @(posedge core_clk_i);
        rdr(oak_pkg::REG_STATUS, rd);
        chk(rd & 32'h0F47, exp_st(c, ef, 32'h46));
        chk(32'({ef_ack_o, od_ack_o}), ef ? 32'h2 : 32'h1);
        if (md[1])
        begin
            repeat (400) @(posedge core_clk_i);
            chk(32'({resume_o, od_ack_o | ef_ack_o}), 32'h1);
            wr(oak_pkg::REG_CTRL, 32'h0);
        end
        for (int i = 0; i < 6000 && busy_o !== 1'b0; i++) @(posedge core_clk_i);
        rdr(oak_pkg::REG_STATUS, rd);
        chk(rd & 32'h0F7F, exp_st(c, ef, 32'h10));
        rdr(oak_pkg::REG_ACTIVE, rd);
        chk(rd, exp_act(c, ef, t));
        if (md == 2'h0)
            chk(ack_len, oak_pkg::ACK_STEPS * oak_pkg::PHASE_CYC);
        else if (md == 2'h1)
            chk(32'(ack_len >= oak_pkg::SLOW_STAGE_CYC), 32'h1);
        $display("test chan=%0d ef=%0d term=%0d dual=%0d mode=%0d done", c, ef, t, du, md);
    endtask
    task automatic end_of_test();
        $display("compared=%0d mismatches=%0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // reset values, read-only and unmapped places, then corner and random sequences
    initial
    begin
        repeat (20) @(posedge core_clk_i);
        rst_n_i <= 1'b1;
        rdr(oak_pkg::REG_CTRL, rd);
        chk(rd, 32'h0);
        wr(oak_pkg::REG_STATUS, 32'hFFFFFFFF);
        rdr(oak_pkg::REG_STATUS, rd);
        chk(rd, 32'h0);
        rdr(4'h2, rd);
        chk(rd, 32'h0);
        $display("test registers done");
        run_seq(0, 1'b0, 1'b1, 1'b0, 2'h0);
        run_seq(3, 1'b1, 1'b1, 1'b1, 2'h0);
        run_seq(1, 1'b0, 1'b1, 1'b1, 2'h1);
        run_seq(2, 1'b0, 1'b1, 1'b0, 2'h2);
        for (int k = 0; k < 6; k++)
        begin
            rv = $random(seed);
            slow <= rv[5];
            run_seq(int'(rv[1:0]), rv[2], rv[3], rv[4], 2'h0);
        end
        end_of_test();
    end
    // watchdog sized well above the longest expected run
    initial
    begin
        repeat (60000) @(posedge core_clk_i);
        errors++;
        end_of_test();
    end
endmodule
